// ===== hw/tlic_top.v
`timescale 1ns/1ps
`include "tlic_map.vh"
module tlic_top (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  srcEvent,
  input  wire        instrTick,
  input  wire [20:0] returnPc,
  input  wire        returnFromHandler,
  output reg         entryStrobe,
  output reg  [20:0] vectorPc,
  output reg  [20:0] pushPc,
  output reg         pushStrobe
);

  // Source map, one bit per source in the flag, enable and priority words.
  // Bits 0 to 2 are core sources (pins and port change), enabled from the core register.
  // Bits 3 and 4 are peripheral slots with no enable bit, so their flags never request.
  // Bit 5 is low-voltage detect, enabled by bit 2 of enable two.
  // Bit 6 is the PWM time base, enabled by bit 4 of enable three.
  // Bit 7 is clock fail, enabled by bit 7 of enable two.
  // Bits 3 to 7 are peripherals and so sit behind the group enable in single-level mode.
  // Register state.
  reg        prioEn_ff;
  reg        gieHigh_ff;
  reg        gieLow_ff;
  reg [7:0]  prio_ff;
  reg [7:0]  flag_ff;
  reg [7:0]  coreEn_ff;
  reg [7:0]  enTwo_ff;
  reg [7:0]  enThree_ff;
  reg        inHigh_ff;
  reg        inLow_ff;
  reg [2:0]  latCnt_ff;
  reg        pendHigh_ff;
  reg        pending_ff;
  reg [7:0]  evA_ff;
  reg [7:0]  evB_ff;
  reg [7:0]  evC_ff;
  reg [7:0]  evPrev_ff;
  reg [31:0] awAddr_ff;
  reg        awHave_ff;
  reg [31:0] wData_ff;
  reg [3:0]  wStrb_ff;
  reg        wHave_ff;

  wire [7:0] enAll;
  wire [7:0] evSync;
  wire [7:0] evRise;
  wire [7:0] reqHigh;
  wire [7:0] reqLow;
  wire [7:0] reqCompat;
  wire       anyHigh;
  wire       anyLow;
  wire       wrFire;
  wire [7:0] wrByte;
  wire [4:0] wrOff;
  wire       flagWr;
  wire       acceptReq;
  wire       tickStep;
  wire       entryDue;

  // True for an address inside the block's 32-byte window; used by both bus channels.
  // Without it a decode of the low bits alone would alias every 32 bytes.
  function addr_hit;
    input [31:0] addr;
    begin
      addr_hit = (addr[31:5] == 27'h0000000);
    end
  endfunction

  // Chooses the readback word for a byte offset; unmapped offsets read zero.
  function [31:0] rd_word;
    input [4:0] off;
    begin
      case (off)
        `TLIC_OFF_RESET_CTRL:   rd_word = {24'h000000, prioEn_ff, 7'h00};
        `TLIC_OFF_INT_CTRL:     rd_word = {24'h000000, gieHigh_ff, gieLow_ff, 6'h00};
        `TLIC_OFF_PRIORITY:     rd_word = {24'h000000, prio_ff};
        `TLIC_OFF_FLAGS:        rd_word = {24'h000000, flag_ff};
        `TLIC_OFF_ENABLE_TWO:   rd_word = {24'h000000, enTwo_ff};
        `TLIC_OFF_ENABLE_THREE: rd_word = {24'h000000, enThree_ff};
        `TLIC_OFF_CORE_STATE:   rd_word = {24'h000000, coreEn_ff[2:0], inHigh_ff, inLow_ff,
                                           pending_ff, pendHigh_ff, 1'b0};
        default:                rd_word = 32'h00000000;
      endcase
    end
  endfunction

  // Requests of one level: flag, own enable, level select and that level's global gate.
  function [7:0] level_req;
    input [7:0] flags;
    input [7:0] enables;
    input [7:0] levelSel;
    input       gate;
    begin
      level_req = flags & enables & levelSel & {8{gate}};
    end
  endfunction

  // Vector of an entry: the low vector only for a low request under the priority scheme.
  function [20:0] entry_vector;
    input isHigh;
    input prioOn;
    begin
      entry_vector = (isHigh || !prioOn) ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW;
    end
  endfunction

  // Per-source enables: core sources from their own register, peripherals from the two.
  assign enAll = {enTwo_ff[`TLIC_BIT_CLK_FAIL], enThree_ff[`TLIC_BIT_PWM_TB],
                  enTwo_ff[`TLIC_BIT_LOW_VOLT], 2'b00, coreEn_ff[2:0]};

  // Event pins pass three flops; a rise counts once the second and third agree.
  assign evSync = (evB_ff == evC_ff) ? evC_ff : evPrev_ff;
  assign evRise = evSync & ~evPrev_ff;

  // Eligible requests per level; enable clear blocks the source.
  assign reqHigh   = level_req(flag_ff, enAll, prio_ff, gieHigh_ff);
  assign reqLow    = level_req(flag_ff, enAll, ~prio_ff, gieLow_ff);
  assign reqCompat = level_req(flag_ff, enAll, ~`TLIC_PERIPH_MASK | {8{gieLow_ff}},
                               gieHigh_ff);
  assign anyHigh = prioEn_ff ? (|reqHigh & ~inHigh_ff) : (|reqCompat);
  assign anyLow  = prioEn_ff & (|reqLow) & ~inHigh_ff & ~inLow_ff;

  assign wrFire = awHave_ff & wHave_ff & ~s_axi_bvalid;
  assign wrByte = wStrb_ff[0] ? wData_ff[7:0] : 8'h00;
  assign wrOff  = addr_hit(awAddr_ff) ? awAddr_ff[4:0] : `TLIC_OFF_NONE;

  // Flag writes and sequencer steps, decoded once for the processes below.
  // A return pulse freezes the sequencer for that cycle, as it did before the split.
  assign flagWr    = wrFire && (wrOff == `TLIC_OFF_FLAGS);
  assign acceptReq = !returnFromHandler && !pending_ff && (anyHigh || anyLow);
  assign tickStep  = !returnFromHandler && pending_ff && instrTick;
  assign entryDue  = tickStep && (latCnt_ff == 3'h1);

  // Pin synchronisers and edge history.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evA_ff    <= 8'h00;
      evB_ff    <= 8'h00;
      evC_ff    <= 8'h00;
      evPrev_ff <= 8'h00;
    end else begin
      evA_ff    <= srcEvent;
      evB_ff    <= evA_ff;
      evC_ff    <= evB_ff;
      evPrev_ff <= evSync;
    end
  end

  // AXI4-Lite slave; address and data may arrive in either order.
  // Each ready pulses for one cycle and is not raised again while its slot is full,
  // so a stalled response back-pressures the next request instead of losing it.
  // Only byte lane 0 is kept; the registers are all eight bits wide.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
      awAddr_ff     <= 32'h00000000;
      awHave_ff     <= 1'b0;
      wData_ff      <= 32'h00000000;
      wStrb_ff      <= 4'h0;
      wHave_ff      <= 1'b0;
    end else begin
      s_axi_awready <= ~awHave_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wHave_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        awAddr_ff <= s_axi_awaddr;
        awHave_ff <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        wHave_ff <= 1'b1;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHave_ff    <= 1'b0;
        wHave_ff     <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word(addr_hit(s_axi_araddr) ? s_axi_araddr[4:0] : `TLIC_OFF_NONE);
        s_axi_rresp  <= 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software-only control bits; a write that misses the map changes nothing.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prioEn_ff  <= 1'b0;
      prio_ff    <= 8'h00;
      coreEn_ff  <= 8'h00;
      enTwo_ff   <= 8'h00;
      enThree_ff <= 8'h00;
    end else if (wrFire) begin
      case (wrOff)
        `TLIC_OFF_RESET_CTRL: begin
          prioEn_ff <= wrByte[`TLIC_BIT_PRIO_EN];
        end
        `TLIC_OFF_PRIORITY: begin
          prio_ff <= wrByte;
        end
        `TLIC_OFF_ENABLE_TWO: begin
          enTwo_ff <= wrByte & `TLIC_MASK_ENABLE_TWO;
        end
        `TLIC_OFF_ENABLE_THREE: begin
          enThree_ff <= wrByte & `TLIC_MASK_ENABLE_THREE;
        end
        `TLIC_OFF_CORE_STATE: begin
          coreEn_ff <= {5'h00, wrByte[7:5]};
        end
        default: ;
      endcase
    end
  end

  // Event flags: a rise sets its flag whatever the enables.
  // Hardware set wins over a software clear in the same cycle, so no event is lost.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 8'h00;
    end else if (flagWr) begin
      flag_ff <= wrByte | evRise;
    end else begin
      flag_ff <= flag_ff | evRise;
    end
  end

  // Global enables and in-progress levels.
  // A return re-arms the enable that entry cleared, innermost level first; it is applied
  // after a software write of the same cycle so the handler's exit is never lost.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gieHigh_ff <= 1'b0;
      gieLow_ff  <= 1'b0;
      inHigh_ff  <= 1'b0;
      inLow_ff   <= 1'b0;
    end else begin
      if (wrFire && wrOff == `TLIC_OFF_INT_CTRL) begin
        gieHigh_ff <= wrByte[`TLIC_BIT_GIE_HIGH];
        gieLow_ff  <= wrByte[`TLIC_BIT_GIE_LOW];
      end
      if (returnFromHandler) begin
        if (!prioEn_ff || inHigh_ff) begin
          gieHigh_ff <= 1'b1;
          inHigh_ff  <= 1'b0;
        end else if (inLow_ff) begin
          gieLow_ff <= 1'b1;
          inLow_ff  <= 1'b0;
        end
      end else if (acceptReq) begin
        // Accept at once and close the level's gate; high wins a tie.
        if (anyHigh) begin
          gieHigh_ff <= 1'b0;
          inHigh_ff  <= 1'b1;
        end else begin
          gieLow_ff <= 1'b0;
          inLow_ff  <= 1'b1;
        end
      end
    end
  end

  // Entry sequencer: the latency counts instruction ticks, so it is the same for one- and
  // two-cycle instructions; a request that arrives meanwhile waits for the next entry.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latCnt_ff   <= 3'h0;
      pendHigh_ff <= 1'b0;
      pending_ff  <= 1'b0;
    end else if (acceptReq) begin
      pending_ff  <= 1'b1;
      pendHigh_ff <= anyHigh;
      latCnt_ff   <= `TLIC_LATENCY;
    end else if (entryDue) begin
      pending_ff <= 1'b0;
      latCnt_ff  <= 3'h0;
    end else if (tickStep) begin
      latCnt_ff <= latCnt_ff - 3'h1;
    end
  end

  // Entry outputs: one-cycle strobes, with vector and return address held until the next.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entryStrobe <= 1'b0;
      pushStrobe  <= 1'b0;
      vectorPc    <= 21'h000000;
      pushPc      <= 21'h000000;
    end else begin
      entryStrobe <= entryDue;
      pushStrobe  <= entryDue;
      if (entryDue) begin
        pushPc   <= returnPc;
        vectorPc <= entry_vector(pendHigh_ff, prioEn_ff);
      end
    end
  end

endmodule

// ===== hw/tlic_map.vh
// Contract
// - Priority mode: high requests vector to 0008h, low requests to 0018h.
// - A high request preempts a running low handler.
// - Each source has a flag, an enable and a priority bit; bits 3 and 4 have no enable bit, so their flags never request.
// - Priority scheme active only while reset control bit 7 is set.
// - Priority mode: control bit 7 enables all high-priority sources.
// - Priority mode: control bit 6 enables all low-priority sources.
// - Flag, enable and matching global enable vector at once; cleared enable blocks.
// - Priority scheme clear by default; priority bits then have no effect.
// - Compatibility mode: bit 6 gates peripherals, bit 7 gates all sources.
// - Compatibility mode: every accepted request branches to 0008h.
// - Acceptance clears the relevant global enable.
// - No low request is accepted during a high handler.
// - Entry pushes the return address and loads the vector.
// - Return sets the global enable that entry cleared.
// - External entry latency is three to four instruction cycles.
// - Flags set on events regardless of any enable.
// - Enable two: bit 7 clock fail, bit 2 low volt; others read 0.
// - Enable three: bit 4 PWM time base; others read 0.
`ifndef TLIC_MAP_VH
`define TLIC_MAP_VH
`define TLIC_OFF_RESET_CTRL   5'h00
`define TLIC_OFF_INT_CTRL     5'h04
`define TLIC_OFF_PRIORITY     5'h08
`define TLIC_OFF_FLAGS        5'h0c
`define TLIC_OFF_ENABLE_TWO   5'h10
`define TLIC_OFF_ENABLE_THREE 5'h14
`define TLIC_OFF_CORE_STATE   5'h18
`define TLIC_OFF_NONE         5'h1f
`define TLIC_BIT_PRIO_EN      7
`define TLIC_BIT_GIE_HIGH     7
`define TLIC_BIT_GIE_LOW      6
`define TLIC_BIT_CLK_FAIL     7
`define TLIC_BIT_LOW_VOLT     2
`define TLIC_BIT_PWM_TB       4
`define TLIC_MASK_ENABLE_TWO  8'h84
`define TLIC_MASK_ENABLE_THREE 8'h10
`define TLIC_VEC_HIGH         21'h000008
`define TLIC_VEC_LOW          21'h000018
`define TLIC_LATENCY          3'h3
`define TLIC_NSRC             8
`define TLIC_PERIPH_MASK      8'hf8
`endif

// ===== dv/tlic_sva.sv
`timescale 1ns/1ps
// Bus answers hold while stalled, and entry outputs pulse together.
module tlic_sva (
  input wire        clk,
  input wire        rst_n,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        entryStrobe,
  input wire [20:0] vectorPc,
  input wire        pushStrobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence bWait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence rWait; s_axi_rvalid && !s_axi_rready; endsequence
  sequence entry; entryStrobe && pushStrobe; endsequence
  // A vector that moved without an entry would send the core somewhere stale.
  a_b_hold: assert property (bWait |=> s_axi_bvalid) else $error("bvalid dropped");
  a_r_hold: assert property (rWait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata moved");
  a_resp_okay: assert property ((s_axi_bvalid || s_axi_rvalid) |-> !(s_axi_bresp | s_axi_rresp))
    else $error("bad resp");
  a_upper_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[31:8])
    else $error("upper bits set");
  a_entry_pair: assert property ((entryStrobe || pushStrobe) |-> entry)
    else $error("push not paired");
  a_vec_legal: assert property (entry |-> vectorPc == 21'h8 || vectorPc == 21'h18)
    else $error("bad vector");
  a_entry_pulse: assert property (entry |=> !entryStrobe ##1 !entryStrobe)
    else $error("entry too long");
  a_vec_hold: assert property (!entryStrobe |-> $stable(vectorPc))
    else $error("vector moved");
endmodule
bind tlic_top tlic_sva i_sva (.clk, .rst_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .entryStrobe, .vectorPc,
  .pushStrobe);

// ===== dv/tlic_core_model.sv
`timescale 1ns/1ps
// Core model: one tick every four clocks, jumps to each vector handed over.
module tlic_core_model (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        entryStrobe,
  input  wire [20:0] vectorPc,
  output reg         instrTick,
  output reg  [20:0] returnPc
);
  reg [1:0] phase_ff;
  // The counter advances per instruction, so each entry sees a fresh return address.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= 2'h0;
      instrTick <= 1'b0;
      returnPc <= 21'h100;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      instrTick <= phase_ff == 2'h3;
      returnPc <= entryStrobe ? vectorPc : returnPc + {20'h0, instrTick};
    end
  end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
// Drivers note expected answers; the watcher matches each answer to the oldest note.
module tb;
  logic clk, rst_n = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, doRet = 0;
  logic [31:0] aw = 0, wd = 0, ar = 0, r, d, seed = 32'h1ad1b60b;
  logic [7:0] src = 8'h0;
  logic [3:0] ws = 4'hf;
  logic [20:0] prevRpc = 21'h0;
  logic [31:0] rdQ[$];
  logic [20:0] vecQ[$];
  int mismatches = 0, comparisons = 0, cyc = 0;
  wire awr, wr, bv, arr, rv, tick, ent, ps;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [20:0] rpc, vpc, ppc;
  tlic_top i_dut (.clk, .rst_n, .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .srcEvent(src), .instrTick(tick),
    .returnPc(rpc), .returnFromHandler(doRet), .entryStrobe(ent), .vectorPc(vpc),
    .pushPc(ppc), .pushStrobe(ps));
  tlic_core_model i_core (.clk, .rst_n, .entryStrobe(ent), .vectorPc(vpc),
    .instrTick(tick), .returnPc(rpc));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // An answer with no note is compared against unknown and so always fails.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rv && rrdy) chk_rd(rdQ.size() ? rdQ.pop_front() : 32'hx, rdata);
    prevRpc <= rpc;
    if (ent) chk_vec(vecQ.size() ? vecQ.pop_front() : 21'hx, vpc);
    if (ent || ps) chk_push({1'b1, prevRpc}, {ps, ppc});
    if (cyc == 6000) begin
      miss("timeout");
      wrap_up();
    end
  end
  task automatic miss(input string m);
    mismatches++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] a);
    comparisons++;
    if (a !== e) miss("read data");
  endtask
  task automatic chk_vec(input logic [20:0] e, input logic [20:0] a);
    comparisons++;
    if (a !== e) miss("entry vector");
  endtask
  task automatic chk_push(input logic [21:0] e, input logic [21:0] a);
    comparisons++;
    if (a !== e) miss("return push");
  endtask
  // Ready is raised late at random so the slave must hold its answer.
  task automatic wreg(input logic [31:0] a, input logic [31:0] v);
    r = $random(seed);
    {aw, wd} <= {a, v};
    {awv, wv, brdy} <= {2'h3, r[0]};
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) brdy <= 1'b1;
    end while (!(bv && brdy));
    brdy <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [31:0] a, input logic [31:0] e);
    r = $random(seed);
    rdQ.push_back(e);
    ar <= a;
    {arv, rrdy} <= {1'b1, r[0]};
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) rrdy <= 1'b1;
    end while (!(rv && rrdy));
    rrdy <= 1'b0;
    @(posedge clk);
  endtask
  // Forty clocks cover sync, flag and three instruction ticks of entry delay.
  task automatic pins(input logic [7:0] s);
    src <= s;
    repeat (40) @(posedge clk);
  endtask
  task automatic ret();
    doRet <= 1'b1;
    @(posedge clk);
    doRet <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  task automatic wrap_up();
    mismatches += rdQ.size() + vecQ.size();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Register access, then single level, then two level entries.
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(8'h10, 8'h0);
    rreg(8'h14, 8'h0);
    rreg(8'h40, 8'h0);
    repeat (2) begin
      d = $random(seed);
      ws <= {3'h7, d[8]};
      wreg(8'h10, d);
      wreg(8'h14, d);
      rreg(8'h10, d[8] ? d & 8'h84 : 8'h0);
      rreg(8'h14, d[8] ? d & 8'h10 : 8'h0);
    end
    ws <= 4'hf;
    $display("test registers done");
    wreg(8'h10, 8'h04);
    wreg(8'h18, 8'he0);
    wreg(8'h08, 8'h02);
    wreg(8'h04, 8'h80);
    pins(8'ha0);
    rreg(8'h0c, 8'ha0);
    wreg(8'h0c, 8'h0);
    vecQ.push_back(21'h8);
    pins(8'h02);
    rreg(8'h04, 8'h0);
    wreg(8'h0c, 8'h0);
    ret();
    rreg(8'h04, 8'h80);
    wreg(8'h04, 8'hc0);
    vecQ.push_back(21'h8);
    pins(8'h20);
    wreg(8'h0c, 8'h0);
    ret();
    $display("test single level done");
    wreg(8'h00, 8'h80);
    wreg(8'h08, 8'h05);
    vecQ.push_back(21'h8);
    pins(8'h03);
    wreg(8'h0c, 8'h02);
    vecQ.push_back(21'h18);
    ret();
    rreg(8'h04, 8'h80);
    wreg(8'h0c, 8'h0);
    vecQ.push_back(21'h8);
    pins(8'h04);
    rreg(8'h04, 8'h0);
    wreg(8'h0c, 8'h0);
    ret();
    ret();
    rreg(8'h04, 8'hc0);
    wreg(8'h18, 8'h0);
    pins(8'h05);
    rreg(8'h0c, 8'h01);
    $display("test two level done");
    wrap_up();
  end
endmodule
